/* inc/tpac_pkg.sv */
// Purpose: shared constants and types of the tag unveil / alarm-flag handler
// Assumes: bits arrive already demodulated, one per strobe, msb first
// Notes:   crc-16 is the usual air-link ccitt form, preset all ones
package tpac_pkg;

  // ---------------------------------------------------------------------
  // command framing
  // ---------------------------------------------------------------------
  localparam logic [15:0] OPC_UNVEIL    = 16'he002;
  localparam logic [15:0] OPC_ALARM     = 16'he003;
  localparam logic [6:0]  UNVEIL_BITS   = 7'h50;  // 16+32+16+16
  localparam logic [6:0]  ALARM_BITS    = 7'h31;  // 16+1+16+16
  localparam int          HANDLE_LSB    = 16;     // handle sits above crc
  localparam int          PWD_LSB       = 32;     // covered password
  localparam int          FLAG_POS      = 32;     // alarm value bit
  localparam int          OPC_LSB_UNV   = 64;
  localparam int          OPC_LSB_ALM   = 33;

  // ---------------------------------------------------------------------
  // crc-16
  // ---------------------------------------------------------------------
  localparam logic [15:0] CRC_PRESET    = 16'hffff;
  localparam logic [15:0] CRC_POLY      = 16'h1021;
  localparam logic [15:0] CRC_RESIDUE   = 16'h1d0f;
  localparam logic [4:0]  OK_REPLY_BITS = 5'h11;  // header + handle
  localparam logic [4:0]  ERR_REPLY_BITS = 5'h19; // header + code + handle

  // ---------------------------------------------------------------------
  // timing: the reader waits at most this long for our answer
  // ---------------------------------------------------------------------
  localparam int          REPLY_LIMIT_US = 20000;
  localparam int          CLK_MHZ        = 125;
  localparam int          REPLY_LIMIT_CYC = REPLY_LIMIT_US * CLK_MHZ;

  // ---------------------------------------------------------------------
  // types
  // ---------------------------------------------------------------------
  typedef enum logic [6:0] {
    TAG_READY     = 7'b0000001,
    TAG_ARBITRATE = 7'b0000010,
    TAG_REPLY     = 7'b0000100,
    TAG_ACK       = 7'b0001000,
    TAG_OPEN      = 7'b0010000,
    TAG_SECURED   = 7'b0100000,
    TAG_KILLED    = 7'b1000000
  } tpac_tag_state_t;

  typedef enum logic [3:0] {
    ST_IDLE   = 4'b0001,
    ST_RECV   = 4'b0010,
    ST_DECIDE = 4'b0100,
    ST_COMMIT = 4'b1000
  } tpac_fsm_t;

  typedef struct packed {
    logic start;     // frame-sync seen
    logic bitValid;
    logic bitVal;
    logic endFrame;
  } tpac_rx_t;

  typedef struct packed {
    logic epcVeil;
    logic tidVeil;
    logic alarmFlag;
  } tpac_cfg_t;

  typedef struct packed {
    logic        valid;
    logic        isError;
    logic        pilotTone;
    logic        header;
    logic [7:0]  errorCode;
    logic [15:0] handle;
    logic [15:0] crc;
  } tpac_reply_t;

endpackage : tpac_pkg

/* hdl/tpac_crc16.sv */
// Purpose: serial crc-16 over received command bits
// Assumes: one bit per enabled cycle, msb first
// Notes:   a clear and a shift in one cycle shift from the preset
`timescale 1ns/1ps
`default_nettype none
module tpac_crc16
  import tpac_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        resetn,
  input  wire logic        clear,
  input  wire logic        shiftEn,
  input  wire logic        dataBit,
  output var  logic [15:0] crc
);

  // ---------------------------------------------------------------------
  // next value
  // ---------------------------------------------------------------------
  logic [15:0] base;
  logic        fb;
  logic [15:0] next_crc;

  assign base     = clear ? CRC_PRESET : crc;
  assign fb       = base[15] ^ dataBit;
  assign next_crc = shiftEn ? ({base[14:0], 1'b0} ^ (fb ? CRC_POLY : 16'h0000))
                            : base;

  // register
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      crc <= CRC_PRESET;
    end else begin
      crc <= next_crc;
    end
  end

endmodule : tpac_crc16
`default_nettype wire

/* hdl/tpac_handler.sv */
// Purpose: unveil and alarm-flag change command handler of a uhf tag
// Assumes: rx strobes, tag state, handle and rn16 come from the same clock
// Notes:   config changes are committed to nvm before any success reply
`timescale 1ns/1ps
`default_nettype none

// Summary of operation
// - successful unveil clears epc and tid veils
// - unveil frame is opcode, password, handle, crc
// - password uncovered by xor with doubled rn16
// - crc checked from opcode through handle
// - success reply is 0, handle, crc
// - internal failure answers with an error code
// - replies always carry the pilot tone
// - wrong password: silence, go to arbitrate
// - unveil outcome follows the tag state table
// - alarm change ignored: zero password, bad crc
// - alarm frame is opcode, value, handle, crc
// - alarm flag follows the value bit
// - fast alarm answered only if flag at power-up
// - alarm change outcome follows tag state table
module tpac_handler
  import tpac_pkg::*;
#(
  parameter int unsigned COMMIT_TIMEOUT_CYC = REPLY_LIMIT_CYC,
  parameter logic [7:0]  ERR_CODE_NVM       = 8'h0f,
  parameter logic [63:0] ALARM_CODE         = 64'h0123456789abcdef // arbitrary
)(
  input  wire logic            clk,
  input  wire logic            resetn,
  input  wire tpac_rx_t        rx,
  input  wire tpac_tag_state_t tagState,
  input  wire logic [15:0]     sessionHandle,
  input  wire logic [15:0]     currentRn16,
  input  wire logic [31:0]     accessPassword,
  input  wire tpac_cfg_t       cfgInit,
  input  wire logic            nvmDone,
  input  wire logic            nvmFail,
  input  wire logic            fastAlarmQuery,
  output var  tpac_cfg_t       cfg,
  output var  logic            nvmReq,
  output var  tpac_cfg_t       nvmData,
  output var  tpac_reply_t     reply,
  output var  logic            goArbitrate,
  output var  logic            fastAlarmReply,
  output var  logic [63:0]     alarmCode
);

  // ---------------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------------
  // crc over the top n bits of a reply, sent inverted
  function automatic logic [15:0] replyCrc(input logic [24:0] d,
                                           input logic [4:0]  n);
    logic [15:0] c;
    logic        f;
    c = CRC_PRESET;
    f = 1'b0;
    for (int i = 24; i >= 25 - int'(n); i--) begin
      f = c[15] ^ d[i];
      c = {c[14:0], 1'b0} ^ (f ? CRC_POLY : 16'h0000);
    end
    return ~c;
  endfunction : replyCrc

  // ---------------------------------------------------------------------
  // receive path
  // ---------------------------------------------------------------------
  tpac_fsm_t   state;
  tpac_fsm_t   next_state;
  logic [79:0] shreg;
  logic [6:0]  bitCount;
  logic        overLong;
  logic [15:0] rxCrc;
  logic        crcClear;
  logic        crcShift;
  // bits before a frame-sync are dropped; the reader must send one
  assign crcClear = rx.start;
  assign crcShift = rx.bitValid && (state == ST_RECV || rx.start);
  tpac_crc16 u_crc (
    .clk     (clk),
    .resetn  (resetn),
    .clear   (crcClear),
    .shiftEn (crcShift),
    .dataBit (rx.bitVal),
    .crc     (rxCrc)
  );
  // shift register and bit counter
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      shreg    <= 80'h0;
      bitCount <= 7'h00;
      overLong <= 1'b0;
    end else if (rx.start) begin
      shreg    <= {79'h0, rx.bitVal & rx.bitValid};
      bitCount <= {6'h00, rx.bitValid};
      overLong <= 1'b0;
    end else if (crcShift) begin
      shreg    <= {shreg[78:0], rx.bitVal};
      bitCount <= bitCount + 7'h01;
      overLong <= overLong | (bitCount == 7'h7f);
    end
  end

  // ---------------------------------------------------------------------
  // decode of the finished frame
  // ---------------------------------------------------------------------
  logic        isUnveil;
  logic        isAlarm;
  logic        crcOk;
  logic        handleOk;
  logic        pwdOk;
  logic        pwdZero;
  logic        flagBit;
  logic [15:0] rxHandle;
  logic [31:0] uncovered;
  logic        stOpenSec;
  logic        stArbGroup;
  assign isUnveil  = !overLong && bitCount == UNVEIL_BITS
                  && shreg[OPC_LSB_UNV +: 16] == OPC_UNVEIL;
  assign isAlarm   = !overLong && bitCount == ALARM_BITS
                  && shreg[OPC_LSB_ALM +: 16] == OPC_ALARM;
  assign crcOk     = rxCrc == CRC_RESIDUE;
  assign rxHandle  = shreg[HANDLE_LSB +: 16];
  assign handleOk  = rxHandle == sessionHandle;
  assign uncovered = shreg[PWD_LSB +: 32]
                   ^ {currentRn16, currentRn16};
  assign pwdOk     = uncovered == accessPassword;
  assign pwdZero   = accessPassword == 32'h0;
  assign flagBit   = shreg[FLAG_POS];
  assign stOpenSec = tagState == TAG_OPEN || tagState == TAG_SECURED;
  assign stArbGroup = tagState == TAG_ARBITRATE || tagState == TAG_REPLY
                   || tagState == TAG_ACK;
  // actions chosen in the decide cycle
  logic unveilGo;
  logic unveilArb;
  logic alarmGo;
  logic alarmArb;
  logic decideArb;
  logic decideGo;
  assign unveilGo  = isUnveil && crcOk && stOpenSec && handleOk
                  && pwdOk;
  assign unveilArb = isUnveil && crcOk
                  && (stArbGroup || (stOpenSec && handleOk
                  && !pwdOk));
  assign alarmGo   = isAlarm && crcOk && !pwdZero
                  && tagState == TAG_SECURED && handleOk;
  assign alarmArb  = isAlarm && crcOk && !pwdZero && stArbGroup;
  assign decideArb = (state == ST_DECIDE) && (unveilArb || alarmArb);
  assign decideGo  = (state == ST_DECIDE) && (unveilGo || alarmGo);

  // ---------------------------------------------------------------------
  // state machine
  // ---------------------------------------------------------------------
  logic [21:0] waitCount;
  logic        timedOut;
  // the watchdog keeps us inside the reader's carrier window
  assign timedOut = waitCount == 22'(COMMIT_TIMEOUT_CYC - 1);
  always_comb begin
    next_state = state;
    case (state)
      ST_IDLE:   if (rx.start) next_state = ST_RECV;
      ST_RECV:   if (rx.endFrame && !rx.start) next_state = ST_DECIDE;
      ST_DECIDE: next_state = decideGo ? ST_COMMIT : ST_IDLE;
      ST_COMMIT: if (nvmDone || timedOut) next_state = ST_IDLE;
      default:   next_state = ST_IDLE;
    endcase
  end
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state <= ST_IDLE;
    end else begin
      state <= next_state;
    end
  end
  // commit watchdog
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      waitCount <= 22'h0;
    end else if (state == ST_COMMIT) begin
      waitCount <= waitCount + 22'h1;
    end else begin
      waitCount <= 22'h0;
    end
  end

  // ---------------------------------------------------------------------
  // nvm commit and configuration word
  // ---------------------------------------------------------------------
  logic      opUnveil;
  logic      initDone;
  logic      commitOk;
  logic      commitErr;
  tpac_cfg_t next_nvmData;
  assign next_nvmData = unveilGo
      ? tpac_cfg_t'{epcVeil: 1'b0, tidVeil: 1'b0,
                    alarmFlag: cfg.alarmFlag}
      : tpac_cfg_t'{epcVeil: cfg.epcVeil, tidVeil: cfg.tidVeil,
                    alarmFlag: flagBit};
  assign commitOk  = state == ST_COMMIT && nvmDone && !nvmFail;
  assign commitErr = state == ST_COMMIT && (nvmDone ? nvmFail : timedOut);
  // request stays up until nvm answers or the watchdog expires; cfg changes only once stored
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      nvmReq   <= 1'b0;
      nvmData  <= '0;
      opUnveil <= 1'b0;
    end else if (decideGo) begin
      nvmReq   <= 1'b1;
      nvmData  <= next_nvmData;
      opUnveil <= unveilGo;
    end else if (state == ST_COMMIT && (nvmDone || timedOut)) begin
      nvmReq   <= 1'b0;
    end
  end
  // power-up copy of stored config, then committed updates
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cfg      <= '0;
      initDone <= 1'b0;
    end else if (!initDone) begin
      cfg      <= cfgInit;
      initDone <= 1'b1;
    end else if (commitOk) begin
      cfg      <= nvmData;
    end
  end

  // ---------------------------------------------------------------------
  // replies and state requests
  // ---------------------------------------------------------------------
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      reply       <= '0;
      goArbitrate <= 1'b0;
    end else begin
      goArbitrate     <= decideArb;
      reply.valid     <= commitOk || commitErr;
      reply.pilotTone <= 1'b1;
      if (commitOk) begin
        reply.isError   <= 1'b0;
        reply.header    <= 1'b0;
        reply.errorCode <= 8'h00;
        reply.handle    <= rxHandle;
        reply.crc       <= replyCrc({1'b0, rxHandle, 8'h00},
                                    OK_REPLY_BITS);
      end else if (commitErr) begin
        reply.isError   <= 1'b1;
        reply.header    <= 1'b1;
        reply.errorCode <= ERR_CODE_NVM;
        reply.handle    <= rxHandle;
        reply.crc       <= replyCrc({1'b1, ERR_CODE_NVM, rxHandle},
                                    ERR_REPLY_BITS);
      end
    end
  end

  // ---------------------------------------------------------------------
  // fast alarm enable, frozen at power-up
  // ---------------------------------------------------------------------
  // a flag written now only takes effect after the next power cycle
  logic fastAlarmEn;
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      fastAlarmEn    <= 1'b0;
      fastAlarmReply <= 1'b0;
      alarmCode      <= 64'h0;
    end else begin
      if (!initDone) begin
        fastAlarmEn <= cfgInit.alarmFlag;
        alarmCode   <= ALARM_CODE;
      end
      fastAlarmReply <= fastAlarmQuery && fastAlarmEn && initDone
                     && tagState == TAG_READY;
    end
  end

  // ---------------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  AST_PILOT: assert property (reply.valid |-> reply.pilotTone)
    else $error("reply without pilot tone");
  AST_UNVEIL_CLEARS: assert property (
    reply.valid && !reply.isError && opUnveil |-> !cfg.epcVeil && !cfg.tidVeil)
    else $error("unveil success but veil bits still set");
  AST_COMMIT_FIRST: assert property (
    reply.valid && !reply.isError |-> $past(nvmDone) && !$past(nvmFail))
    else $error("success reply before nvm commit");
  AST_REPLY_FORM: assert property (
    reply.valid && !reply.isError |-> !reply.header && reply.handle == rxHandle
      && reply.crc == replyCrc({1'b0, rxHandle, 8'h00}, OK_REPLY_BITS))
    else $error("bad success reply contents");
  AST_BADPWD_ARB: assert property (
    state == ST_DECIDE && isUnveil && crcOk && stOpenSec && handleOk && !pwdOk
      |=> goArbitrate && !nvmReq ##1 !reply.valid)
    else $error("wrong password not handled");
  AST_ALARM_ZERO_PWD: assert property (
    state == ST_DECIDE && isAlarm && pwdZero |=> !goArbitrate && !nvmReq)
    else $error("alarm change with zero password acted on");
  AST_ALARM_VALUE: assert property (
    reply.valid && !reply.isError && !opUnveil |-> cfg.alarmFlag == flagBit)
    else $error("alarm flag not equal to value bit");
  AST_ERR_REPLY: assert property (
    state == ST_COMMIT && nvmDone && nvmFail |=> reply.valid && reply.isError
      && reply.errorCode == ERR_CODE_NVM)
    else $error("nvm failure without error reply");
  AST_FAST_ALARM: assert property (
    fastAlarmReply |-> $past(fastAlarmEn) && $past(tagState) == TAG_READY)
    else $error("fast alarm answered while disabled");
  AST_ALARM_IGNORE: assert property (
    state == ST_DECIDE && isAlarm && (tagState == TAG_OPEN
      || tagState == TAG_READY || tagState == TAG_KILLED)
      |=> state == ST_IDLE && !goArbitrate && !nvmReq)
    else $error("alarm change not ignored in this state");
  AST_BAD_HANDLE: assert property (
    state == ST_DECIDE && stOpenSec && !handleOk |=> !goArbitrate && !nvmReq)
    else $error("invalid handle acted on");
  AST_CRC_GATE: assert property (
    state == ST_DECIDE && !crcOk |=> !goArbitrate && !nvmReq [*2])
    else $error("bad crc frame acted on");
  COV_UNVEIL_OK: cover property (reply.valid && !reply.isError && opUnveil);
  COV_ALARM_OK: cover property (reply.valid && !reply.isError && !opUnveil);
  COV_ERR: cover property (reply.valid && reply.isError);
  COV_ARB: cover property (goArbitrate);
endmodule : tpac_handler
`default_nettype wire

/* tb/tpac_reader_model.sv */
// Purpose: interrogator model that frames commands for the tag handler
// Assumes: one demodulated bit per clock, msb first, no air timing
// Notes:   bit line is inverted in the end-of-frame cycle, then holds the last bit, so a stale value is never trusted
`timescale 1ns/1ps
`default_nettype none
module tpac_reader_model
  import tpac_pkg::*;
(
  input  wire logic     clk,
  output var  tpac_rx_t rx
);
  // ------------------------------------------------------------------
  // framing
  // ------------------------------------------------------------------
  initial rx = '0;

  // crc-16 over the low n bits of v, msb first
  function automatic logic [15:0] crc16(input logic [63:0] v, input int n);
    logic [15:0] c;
    c = CRC_PRESET;
    for (int i = n - 1; i >= 0; i--) begin
      c = {c[14:0], 1'b0} ^ ((c[15] ^ v[i]) ? CRC_POLY : 16'h0000);
    end
    return c;
  endfunction : crc16

  // sync with the first bit, payload, inverted crc, then end of frame
  task automatic send(input logic [63:0] v, input int n, input logic bad);
    logic [79:0] w;
    w = ({16'h0000, v} << 16) | {64'h0, ~crc16(v, n) ^ {15'h0, bad}};
    for (int i = n + 15; i >= 0; i--) begin
      @(posedge clk);
      rx <= '{start: (i == n + 15), bitValid: 1'b1, bitVal: w[i],
              endFrame: 1'b0};
    end
    @(posedge clk);
    rx <= '{start: 1'b0, bitValid: 1'b0, bitVal: ~w[0], endFrame: 1'b1};
    @(posedge clk);
    rx <= '{start: 1'b0, bitValid: 1'b0, bitVal: w[0], endFrame: 1'b0};
  endtask : send

  // password covered with the doubled fresh random number
  task automatic unveil(input logic [31:0] pwd, input logic [15:0] rn,
                        input logic [15:0] h, input logic bad);
    send({OPC_UNVEIL, pwd ^ {rn, rn}, h}, 64, bad);
  endtask : unveil

  task automatic alarm(input logic val, input logic [15:0] h,
                       input logic bad);
    send({31'h0, OPC_ALARM, val, h}, 33, bad);
  endtask : alarm
endmodule : tpac_reader_model
`default_nettype wire

/* tb/tb_tag_protect_alarm_cmds.sv */
// Purpose: self-checking bench of the unveil / alarm-flag handler
// Assumes: reader model sends whole frames, the bench answers nvm
// Notes:   commit timeout shortened to 50 cycles to keep runs short
`timescale 1ns/1ps
`default_nettype none
module tb_tag_protect_alarm_cmds
  import tpac_pkg::*;
;
  // ------------------------------------------------------------------
  // signals and design
  // ------------------------------------------------------------------
  localparam int          NONE     = 0;
  localparam int          ARB      = 1;
  localparam int          OK       = 2;
  localparam int          ERR      = 3;
  localparam int          TMO      = 4;  // store never answers
  localparam logic [63:0] ALM_CODE = 64'h5a5a0f0f3c3c9669; // arbitrary
  localparam logic [7:0]  ERR_NVM  = 8'h0f;
  logic            clk, resetn, nvmDone, nvmFail, fastAlarmQuery;
  logic            goArbitrate, nvmReq, fastAlarmReply;
  tpac_rx_t        rx;
  tpac_tag_state_t tagState;
  logic [15:0]     hnd, rn;
  logic [31:0]     pwd;
  tpac_cfg_t       cfgInit, cfg, nvmData, expCfg;
  tpac_reply_t     reply;
  logic [63:0]     alarmCode;
  int              errCount, checksDone, cycles;
  tpac_tag_state_t sts [7] = '{TAG_READY, TAG_ARBITRATE, TAG_REPLY,
                               TAG_ACK, TAG_OPEN, TAG_SECURED, TAG_KILLED};
  int              unvK [7] = '{NONE, ARB, ARB, ARB, OK, OK, NONE};
  int              almK [7] = '{NONE, ARB, ARB, ARB, NONE, OK, NONE};

  tpac_handler #(.COMMIT_TIMEOUT_CYC(50), .ERR_CODE_NVM(ERR_NVM),
                 .ALARM_CODE(ALM_CODE)) dut (
    .clk(clk), .resetn(resetn), .rx(rx), .tagState(tagState),
    .sessionHandle(hnd), .currentRn16(rn), .accessPassword(pwd),
    .cfgInit(cfgInit), .nvmDone(nvmDone), .nvmFail(nvmFail),
    .fastAlarmQuery(fastAlarmQuery), .cfg(cfg), .nvmReq(nvmReq),
    .nvmData(nvmData), .reply(reply), .goArbitrate(goArbitrate),
    .fastAlarmReply(fastAlarmReply), .alarmCode(alarmCode));

  tpac_reader_model rdr (.clk(clk), .rx(rx));

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // hang guard: the whole sequence needs well under this many cycles
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      errCount++;
      wrapUp;
    end
  end

  // ------------------------------------------------------------------
  // tasks
  // ------------------------------------------------------------------
  task automatic chk(input string what, input logic [63:0] exp,
                     input logic [63:0] got);
    checksDone++;
    if (got !== exp) begin
      errCount++;
      $display("wrong value %s: expected %h, seen %h", what, exp, got);
    end
  endtask : chk

  task automatic wrapUp;
    if (errCount == 0 && checksDone > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : wrapUp

  // power-up with a given stored config word
  task automatic doReset(input tpac_cfg_t init);
    cfgInit <= init;
    resetn  <= 1'b0;
    repeat (20) @(posedge clk);
    resetn  <= 1'b1;
    repeat (2) @(posedge clk);
    expCfg = init;
  endtask : doReset

  // watch a bounded window, answering the nvm like a real store would
  task automatic outcome(input int kind, input logic fail,
                         input tpac_cfg_t want);
    logic [63:0] sawArb, sawReq, sawRep;
    logic [15:0] expCrc;
    sawArb = 0;
    sawReq = 0;
    sawRep = 0;
    expCrc = fail ? ~rdr.crc16({39'h0, 1'b1, ERR_NVM, hnd}, 25)
                  : ~rdr.crc16({47'h0, 1'b0, hnd}, 17);
    for (int i = 0; i < 80; i++) begin
      @(negedge clk);
      if (goArbitrate === 1'b1) sawArb++;
      if (reply.valid === 1'b1) begin
        sawRep++;
        chk("reply header", fail, reply.header);
        chk("reply error", fail, reply.isError);
        chk("reply handle", hnd, reply.handle);
        chk("reply crc", expCrc, reply.crc);
        if (fail) chk("reply code", ERR_NVM, reply.errorCode);
      end
      if (nvmReq === 1'b1 && sawReq == 0) begin
        sawReq = 1;
        chk("nvm data", want, nvmData);
        @(posedge clk);
        nvmDone <= (kind != TMO);
        nvmFail <= fail;
        @(posedge clk);
        nvmDone <= 1'b0;
      end
    end
    chk("arbitrate pulses", kind == ARB, sawArb);
    chk("replies", kind >= OK, sawRep);
    chk("nvm requests", kind >= OK, sawReq);
    if (kind == OK) expCfg = want;
    chk("config word", expCfg, cfg);
  endtask : outcome

  task automatic runUnv(input tpac_tag_state_t st, input logic [31:0] p,
                        input logic [15:0] h, input logic bad,
                        input int kind);
    logic [15:0] fresh;
    fresh = rn + 16'h1357;
    @(posedge clk);
    rn       <= fresh;
    tagState <= st;
    rdr.unveil(p, fresh, h, bad);
    outcome(kind, 1'b0, {2'b00, expCfg.alarmFlag});
  endtask : runUnv

  task automatic runAlm(input tpac_tag_state_t st, input logic val,
                        input logic [15:0] h, input logic bad,
                        input logic fail, input int kind);
    @(posedge clk);
    tagState <= st;
    rdr.alarm(val, h, bad);
    outcome(kind, fail, {expCfg.epcVeil, expCfg.tidVeil, val});
  endtask : runAlm

  task automatic fast(input logic exp);
    @(posedge clk);
    tagState       <= TAG_READY;
    fastAlarmQuery <= 1'b1;
    @(posedge clk);
    fastAlarmQuery <= 1'b0;
    @(negedge clk);
    chk("fast alarm reply", exp, fastAlarmReply);
  endtask : fast

  // ------------------------------------------------------------------
  // sequence
  // ------------------------------------------------------------------
  initial begin
    resetn = 1'b0;
    nvmDone = 1'b0;
    nvmFail = 1'b0;
    fastAlarmQuery = 1'b0;
    tagState = TAG_SECURED;
    hnd = 16'h5a3c;
    rn = 16'h1234;
    pwd = 32'h89abcdef;
    cfgInit = '0;
    errCount = 0;
    checksDone = 0;
    cycles = 0;
    doReset(3'b110);
    @(negedge clk);
    chk("config after reset", 3'b110, cfg);
    chk("pilot tone", 1'b1, reply.pilotTone);
    chk("alarm code", ALM_CODE, alarmCode);
    fast(1'b0);
    for (int i = 0; i < 7; i++) runUnv(sts[i], pwd, hnd, 1'b0, unvK[i]);
    doReset(3'b110);
    runUnv(TAG_OPEN, pwd ^ 32'h00000100, hnd, 1'b0, ARB);
    runUnv(TAG_SECURED, pwd, hnd ^ 16'h0001, 1'b0, NONE);
    runUnv(TAG_SECURED, pwd, hnd, 1'b1, NONE);
    runUnv(TAG_SECURED, pwd, hnd, 1'b0, OK);
    for (int i = 0; i < 7; i++)
      runAlm(sts[i], 1'b1, hnd, 1'b0, 1'b0, almK[i]);
    runAlm(TAG_SECURED, 1'b0, hnd, 1'b0, 1'b0, OK);
    runAlm(TAG_SECURED, 1'b1, hnd ^ 16'h8000, 1'b0, 1'b0, NONE);
    runAlm(TAG_SECURED, 1'b1, hnd, 1'b1, 1'b0, NONE);
    runAlm(TAG_SECURED, 1'b1, hnd, 1'b0, 1'b1, ERR);
    runAlm(TAG_SECURED, 1'b1, hnd, 1'b0, 1'b1, TMO);
    @(posedge clk);
    pwd <= '0;
    runAlm(TAG_SECURED, 1'b1, hnd, 1'b0, 1'b0, NONE);
    @(posedge clk);
    pwd <= 32'h89abcdef;
    runAlm(TAG_SECURED, 1'b1, hnd, 1'b0, 1'b0, OK);
    fast(1'b0);
    doReset(3'b001);
    fast(1'b1);
    wrapUp;
  end
endmodule : tb_tag_protect_alarm_cmds
`default_nettype wire
